/* File: design/smf_top.sv */
`timescale 1ns/1ns
module smf_top #(
    parameter bit SLAVE_CAPABLE = 1'b1
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // configuration
    input wire logic target_role_select_in,
    input wire logic clock_format_select_in,
    input wire logic queue_direction_in,
    input wire logic lsb_first_select_in,
    input wire logic two_wire_select_in,
    input wire logic first_byte_command_mode_in,
    input wire logic slave_out_fixed_in,
    input wire logic data_out_line_drive_en_in,
    input wire logic clock_pin_drive_en_in,
    input wire logic data_in_line_drive_en_in,
    input wire logic gpio_out_value_in,
    input wire logic [7:0] serial_clock_divisor_in,
    input wire logic [7:0] slave_preset_byte_in,
    input wire logic clear_all_in,
    // length counter
    input wire logic length_wr_in,
    input wire logic [15:0] length_data_in,
    output logic [smf_pkg::LEN_W-1:0] remaining_length_counter_out,
    // queue data port
    input wire logic queue_wr_valid_in,
    input wire logic [7:0] queue_wr_data_in,
    output logic queue_wr_ready_out,
    output logic queue_rd_valid_out,
    output logic [7:0] queue_rd_data_out,
    input wire logic queue_rd_ready_in,
    output logic [smf_pkg::CNT_W-1:0] queue_byte_count_out,
    // shift buffer
    input wire logic buffer_wr_in,
    input wire logic [7:0] buffer_wr_data_in,
    output logic [7:0] shift_buffer_reg_out,
    // status
    output logic idle_flag_out,
    output logic fifo_ready_out,
    output logic half_full_out,
    output logic byte_done_out,
    output logic overflow_out,
    output logic slave_selected_out,
    output logic command_valid_out,
    output logic [7:0] command_byte_out,
    // dma
    input wire logic dma_transfer_enable_in,
    input wire logic [smf_pkg::ADDR_W-1:0] dma_start_address_in,
    input wire logic [smf_pkg::ADDR_W-1:0] dma_stop_address_in,
    output logic dma_req_out,
    output logic dma_we_out,
    output logic [smf_pkg::ADDR_W-1:0] dma_addr_out,
    output logic [7:0] dma_wdata_out,
    input wire logic [7:0] dma_rdata_in,
    input wire logic dma_ack_in,
    output logic dma_end_out,
    // spi pins
    input wire logic chip_select_input_n_in,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_out,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_out,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_out
);
    import smf_pkg::*;

    // pin synchronisers
    logic [3:0] pin_raw, sync1, sync2, sync3, pin_stable, pin_prev;
    logic cs_active, sck_s, mosi_s, miso_s, sck_rise, sck_fall;
    assign pin_raw = {chip_select_input_n_in, sck_in, mosi_in, miso_in};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    sync1[gi] <= PIN_RESET[gi];
                    sync2[gi] <= PIN_RESET[gi];
                    sync3[gi] <= PIN_RESET[gi];
                    pin_stable[gi] <= PIN_RESET[gi];
                    pin_prev[gi] <= PIN_RESET[gi];
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        pin_stable[gi] <= sync3[gi];
                    end
                    pin_prev[gi] <= pin_stable[gi];
                end
            end
        end
    endgenerate
    assign cs_active = !pin_stable[3];
    assign sck_s = pin_stable[2];
    assign mosi_s = pin_stable[1];
    assign miso_s = pin_stable[0];
    assign sck_rise = sck_s & !pin_prev[2];
    assign sck_fall = !sck_s & pin_prev[2];

    // queue and dma wiring
    logic slave_mode, dir_rx;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [7:0] f_in_data, f_out_data;
    logic eng_push, eng_pop, dma_push, dma_pop;
    logic [7:0] eng_push_data, dma_push_data;
    assign slave_mode = SLAVE_CAPABLE & target_role_select_in;
    assign dir_rx = queue_direction_in;

    // queue role follows the direction bit; dma replaces the processor port
    assign f_in_valid = dir_rx ? eng_push : (dma_transfer_enable_in ? dma_push : queue_wr_valid_in);
    assign f_in_data = dir_rx ? eng_push_data : (dma_transfer_enable_in ? dma_push_data : queue_wr_data_in);
    assign f_out_ready = dir_rx ? (dma_transfer_enable_in ? dma_pop : queue_rd_ready_in) : eng_pop;
    assign queue_wr_ready_out = !dir_rx & !dma_transfer_enable_in & f_in_ready;
    assign queue_rd_valid_out = dir_rx & !dma_transfer_enable_in & f_out_valid;
    assign queue_rd_data_out = f_out_data;

    smf_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .CW(CNT_W)
    ) u_fifo (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .flush_in(clear_all_in),
        .in_valid_in(f_in_valid),
        .in_data_in(f_in_data),
        .in_ready_out(f_in_ready),
        .out_valid_out(f_out_valid),
        .out_data_out(f_out_data),
        .out_ready_in(f_out_ready),
        .count_out(queue_byte_count_out)
    );

    smf_dma u_dma (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .enable_in(dma_transfer_enable_in),
        .to_memory_in(dir_rx),
        .start_in(dma_start_address_in),
        .stop_in(dma_stop_address_in),
        .fifo_in_ready_in(f_in_ready),
        .push_out(dma_push),
        .push_data_out(dma_push_data),
        .fifo_out_valid_in(f_out_valid),
        .fifo_out_data_in(f_out_data),
        .pop_out(dma_pop),
        .mem_req_out(dma_req_out),
        .mem_we_out(dma_we_out),
        .mem_addr_out(dma_addr_out),
        .mem_wdata_out(dma_wdata_out),
        .mem_rdata_in(dma_rdata_in),
        .mem_ack_in(dma_ack_in),
        .end_out(dma_end_out)
    );

    // master engine
    smf_mstate_type mstate;
    logic [7:0] mcnt, mtx, mrx, buf_data, div_eff, half;
    logic [3:0] mbit;
    logic msck, buf_pend, m_direct, m_start, m_done, m_bit_out, m_src_ok;
    assign div_eff = (serial_clock_divisor_in < DIV_MIN) ? DIV_MIN : serial_clock_divisor_in;
    assign half = {1'b0, div_eff[7:1]};
    assign m_src_ok = dir_rx ? f_in_ready : f_out_valid;
    assign m_start = !slave_mode & (mstate == SMF_M_IDLE)
        & (buf_pend | ((remaining_length_counter_out != LEN_RESET) & m_src_ok));
    assign m_done = (mstate == SMF_M_XFER) & (mcnt == div_eff - 8'h01) & (mbit == LAST_BIT);
    assign m_bit_out = lsb_first_select_in ? mtx[0] : mtx[7];

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mstate <= SMF_M_IDLE;
            mcnt <= BYTE_RESET;
            mbit <= BIT_ZERO;
            mtx <= BYTE_RESET;
            mrx <= BYTE_RESET;
            msck <= 1'b0;
            m_direct <= 1'b0;
        end else if (clear_all_in) begin
            mstate <= SMF_M_IDLE;
            msck <= clock_format_select_in;
        end else begin
            case (mstate)
                SMF_M_IDLE: begin
                    msck <= clock_format_select_in;
                    if (m_start) begin
                        mstate <= SMF_M_XFER;
                        mcnt <= BYTE_RESET;
                        mbit <= BIT_ZERO;
                        msck <= 1'b0;
                        m_direct <= buf_pend;
                        mtx <= buf_pend ? buf_data : (dir_rx ? FILL_BYTE : f_out_data);
                    end
                end
                SMF_M_XFER: begin
                    mcnt <= mcnt + 8'h01;
                    if (mcnt == half - 8'h01) begin
                        msck <= 1'b1;
                        // sample on the rising edge
                        mrx <= lsb_first_select_in ? {miso_s, mrx[7:1]} : {mrx[6:0], miso_s};
                    end
                    if (mcnt == div_eff - 8'h01) begin
                        mcnt <= BYTE_RESET;
                        if (mbit == LAST_BIT) begin
                            mstate <= SMF_M_IDLE;
                            msck <= clock_format_select_in;
                        end else begin
                            mbit <= mbit + 4'h1;
                            msck <= 1'b0;
                            // change data on the falling edge
                            mtx <= lsb_first_select_in ? {1'b0, mtx[7:1]} : {mtx[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    mstate <= SMF_M_IDLE;
                end
            endcase
        end
    end

    // direct byte written to the shift buffer
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            buf_pend <= 1'b0;
            buf_data <= BYTE_RESET;
        end else begin
            if (clear_all_in | (m_start & buf_pend)) begin
                buf_pend <= 1'b0;
            end
            if (buffer_wr_in & !slave_mode) begin
                buf_pend <= 1'b1;
                buf_data <= buffer_wr_data_in;
            end
        end
    end

    // length counter, master only
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            remaining_length_counter_out <= LEN_RESET;
        end else if (clear_all_in) begin
            remaining_length_counter_out <= LEN_RESET;
        end else if (length_wr_in) begin
            remaining_length_counter_out <= length_data_in[LEN_W-1:0];
        end else if (m_done & !m_direct & (remaining_length_counter_out != LEN_RESET)) begin
            remaining_length_counter_out <= remaining_length_counter_out - 12'h001;
        end
    end

    // slave engine
    logic [7:0] stx, srx, next_srx, s_next_tx;
    logic [3:0] sbit;
    logic sel, sfresh, sfirst, s_done, s_load, s_pop, s_bit_out, s_starve;
    assign next_srx = lsb_first_select_in ? {mosi_s, srx[7:1]} : {srx[6:0], mosi_s};
    assign s_done = sel & sck_rise & (sbit == LAST_BIT);
    assign s_load = sel & sck_fall & (sbit == BIT_ZERO) & !sfresh;
    assign s_next_tx = (!dir_rx & f_out_valid) ? f_out_data : FILL_BYTE;
    assign s_pop = slave_mode & !dir_rx & f_out_valid
        & ((!sel & cs_active & !first_byte_command_mode_in) | s_load);
    assign s_starve = slave_mode & !dir_rx & !f_out_valid
        & ((!sel & cs_active & !first_byte_command_mode_in) | s_load);
    assign s_bit_out = lsb_first_select_in ? stx[0] : stx[7];

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel <= 1'b0;
            sfresh <= 1'b1;
            sfirst <= 1'b0;
            sbit <= BIT_ZERO;
            stx <= BYTE_RESET;
            srx <= BYTE_RESET;
        end else if (!slave_mode | !cs_active) begin
            sel <= 1'b0;
            sfresh <= 1'b1;
            sbit <= BIT_ZERO;
        end else if (!sel) begin
            sel <= 1'b1;
            sfresh <= 1'b1;
            sbit <= BIT_ZERO;
            sfirst <= first_byte_command_mode_in;
            // preset goes out first, its leading bit shows before any clock
            stx <= first_byte_command_mode_in ? slave_preset_byte_in : s_next_tx;
        end else begin
            if (sck_rise) begin
                sfresh <= 1'b0;
                srx <= next_srx;
                sbit <= (sbit == LAST_BIT) ? BIT_ZERO : sbit + 4'h1;
                if (s_done) begin
                    sfirst <= 1'b0;
                end
            end
            if (s_load) begin
                stx <= s_next_tx;
            end else if (sck_fall & !sfresh) begin
                stx <= lsb_first_select_in ? {1'b0, stx[7:1]} : {stx[6:0], 1'b0};
            end
        end
    end

    // received bytes into the queue, command byte kept apart
    assign eng_push = dir_rx & (m_done | (s_done & !sfirst));
    assign eng_push_data = m_done ? mrx : next_srx;
    assign eng_pop = (m_start & !buf_pend & !dir_rx) | s_pop;

    // exchanged byte, command capture and event pulses
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_buffer_reg_out <= BYTE_RESET;
            command_byte_out <= BYTE_RESET;
            command_valid_out <= 1'b0;
            byte_done_out <= 1'b0;
            overflow_out <= 1'b0;
        end else begin
            if (m_done) begin
                shift_buffer_reg_out <= mrx;
            end else if (s_done) begin
                shift_buffer_reg_out <= next_srx;
            end
            if (s_done & sfirst) begin
                command_byte_out <= next_srx;
            end
            command_valid_out <= s_done & sfirst;
            byte_done_out <= m_done | s_done;
            overflow_out <= s_starve | (s_done & !sfirst & dir_rx & !f_in_ready);
        end
    end

    // status
    assign idle_flag_out = (mstate == SMF_M_IDLE) & !buf_pend & !sel;
    assign fifo_ready_out = (remaining_length_counter_out != LEN_RESET) & m_src_ok;
    assign half_full_out = dir_rx ? (queue_byte_count_out >= FIFO_HALF)
        : (queue_byte_count_out < FIFO_HALF);
    assign slave_selected_out = sel;

    // pin drive
    assign sck_out = msck;
    assign sck_oe_out = !slave_mode & clock_pin_drive_en_in;
    assign mosi_out = m_bit_out;
    assign mosi_oe_out = !slave_mode & !two_wire_select_in & data_out_line_drive_en_in;
    assign miso_out = slave_mode ? (data_in_line_drive_en_in ? s_bit_out : gpio_out_value_in)
        : m_bit_out;
    assign miso_oe_out = slave_mode ? (slave_out_fixed_in | sel)
        : data_in_line_drive_en_in;
endmodule // smf_top

/* File: design/smf_pkg.sv */
package smf_pkg;
    // queue geometry
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] FIFO_HALF = 4'h4;
    // length counter and dma address widths
    localparam int LEN_W = 12;
    localparam int ADDR_W = 15;
    localparam logic [LEN_W-1:0] LEN_RESET = 12'h000;
    // serial clock divisor floor
    localparam logic [7:0] DIV_MIN = 8'h02;
    // bit counting within one byte
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    // byte sent when there is no queued data
    localparam logic [7:0] FILL_BYTE = 8'hff;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // pin synchroniser reset: {chip select n, clock, mosi, miso}
    localparam logic [3:0] PIN_RESET = 4'h8;
    // master engine states
    typedef enum logic [1:0] {
        SMF_M_IDLE = 2'b01,
        SMF_M_XFER = 2'b10
    } smf_mstate_type;
endpackage

/* File: design/smf_fifo.sv */
`timescale 1ns/1ns
module smf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic flush_in,
    // fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in,
    // fill level
    output logic [CW-1:0] count_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wptr, rptr;
    logic do_wr, do_rd;
    assign in_ready_out = (count_out != CW'(DEPTH));
    assign out_valid_out = (count_out != '0);
    assign out_data_out = mem[rptr];
    assign do_wr = in_valid_in & in_ready_out;
    assign do_rd = out_ready_in & out_valid_out;
    always_ff @(posedge mclk_in) begin
        if (do_wr) begin
            mem[wptr] <= in_data_in;
        end
    end
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wptr <= '0;
            rptr <= '0;
            count_out <= '0;
        end else if (flush_in) begin
            wptr <= '0;
            rptr <= '0;
            count_out <= '0;
        end else begin
            if (do_wr) begin
                wptr <= (wptr == PW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (do_rd) begin
                rptr <= (rptr == PW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
            end
            count_out <= count_out + CW'(do_wr) - CW'(do_rd);
        end
    end
endmodule // smf_fifo

/* File: design/smf_dma.sv */
`timescale 1ns/1ns
module smf_dma (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // control
    input wire logic enable_in,
    input wire logic to_memory_in,
    input wire logic [smf_pkg::ADDR_W-1:0] start_in,
    input wire logic [smf_pkg::ADDR_W-1:0] stop_in,
    // queue side
    input wire logic fifo_in_ready_in,
    output logic push_out,
    output logic [7:0] push_data_out,
    input wire logic fifo_out_valid_in,
    input wire logic [7:0] fifo_out_data_in,
    output logic pop_out,
    // memory side
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [smf_pkg::ADDR_W-1:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic mem_ack_in,
    output logic end_out
);
    import smf_pkg::*;
    logic can_go;
    // stop address is exclusive: last byte is at stop - 1
    assign can_go = enable_in & !mem_req_out & !end_out & (mem_addr_out != stop_in);
    assign pop_out = can_go & to_memory_in & fifo_out_valid_in;
    assign push_out = mem_req_out & mem_ack_in & !mem_we_out;
    assign push_data_out = mem_rdata_in;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_addr_out <= '0;
            mem_wdata_out <= BYTE_RESET;
            end_out <= 1'b0;
        end else if (!enable_in) begin
            mem_req_out <= 1'b0;
            mem_addr_out <= start_in;
            end_out <= 1'b0;
        end else if (mem_req_out) begin
            if (mem_ack_in) begin
                mem_req_out <= 1'b0;
                mem_addr_out <= mem_addr_out + 1'b1;
            end
        end else if (mem_addr_out == stop_in) begin
            end_out <= 1'b1;
        end else if (can_go & (to_memory_in ? fifo_out_valid_in : fifo_in_ready_in)) begin
            mem_req_out <= 1'b1;
            mem_we_out <= to_memory_in;
            mem_wdata_out <= fifo_out_data_in;
        end
    end
endmodule // smf_dma

/* File: bench/smf_asserts.sv */
`timescale 1ns/1ns
module smf_asserts (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // configuration
    input wire logic target_role_select_in,
    input wire logic clock_format_select_in,
    input wire logic queue_direction_in,
    input wire logic clear_all_in,
    input wire logic length_wr_in,
    input wire logic [15:0] length_data_in,
    input wire logic [7:0] serial_clock_divisor_in,
    // status
    input wire logic [smf_pkg::LEN_W-1:0] remaining_length_counter_out,
    input wire logic [smf_pkg::CNT_W-1:0] queue_byte_count_out,
    input wire logic half_full_out,
    input wire logic fifo_ready_out,
    input wire logic idle_flag_out,
    input wire logic byte_done_out,
    input wire logic sck_out
);
    import smf_pkg::*;
    logic [LEN_W-1:0] rem;
    logic [CNT_W-1:0] cnt;
    assign rem = remaining_length_counter_out;
    assign cnt = queue_byte_count_out;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    a_len_load: assert property (
        length_wr_in && !clear_all_in && rem == 12'h000 |=> rem == $past(length_data_in[11:0]))
        else $error("bad length load");
    a_len_step: assert property (
        $changed(rem) && !$past(length_wr_in) && !$past(clear_all_in)
        |-> rem == $past(rem) - 12'h001) else $error("bad length step");
    a_cnt_step: assert property (
        !$past(clear_all_in) |-> cnt == $past(cnt) || cnt == $past(cnt) + 4'h1
        || cnt + 4'h1 == $past(cnt)) else $error("bad count step");
    a_cnt_max: assert property (cnt <= 4'h8) else $error("count above depth");
    a_half_mark: assert property (
        half_full_out == (queue_direction_in ? cnt >= FIFO_HALF : cnt < FIFO_HALF))
        else $error("bad half mark");
    a_fifo_rdy: assert property (
        fifo_ready_out == (rem != 12'h000 && (queue_direction_in ? cnt < 4'h8 : cnt != 4'h0)))
        else $error("bad fifo ready");
    a_sck_idle: assert property (
        !target_role_select_in && idle_flag_out && $past(idle_flag_out)
        && $stable(clock_format_select_in) |-> sck_out == clock_format_select_in)
        else $error("bad idle clock level");
    a_sck_high: assert property (
        $rose(sck_out) && !clock_format_select_in && serial_clock_divisor_in == 8'h0a
        |-> sck_out [*5] ##1 !sck_out) else $error("bad clock high time");
    c_tx: cover property (byte_done_out && !queue_direction_in);
    c_rx: cover property (byte_done_out && queue_direction_in);
    c_load: cover property (length_wr_in ##1 rem != 12'h000);
endmodule // smf_asserts

/* File: bench/smf_peer_model.sv */
`timescale 1ns/1ns
module smf_peer_model (
    // serial pins
    input wire logic sck_in,
    input wire logic mosi_in,
    output logic miso_out,
    // control
    input wire logic load_in,
    input wire logic [7:0] tx_byte_in,
    output logic [7:0] rx_byte_out
);
    logic [7:0] tx;
    logic seen;
    assign miso_out = tx[7];
    always @(posedge sck_in or posedge load_in) begin
        if (load_in) begin
            seen <= 1'b0;
        end else begin
            seen <= 1'b1;
            rx_byte_out <= {rx_byte_out[6:0], mosi_in};
        end
    end
    always @(negedge sck_in or posedge load_in) begin
        if (load_in) begin
            tx <= tx_byte_in;
        end else if (seen) begin
            tx <= {tx[6:0], ~tx[7]};
        end
    end
endmodule // smf_peer_model

/* File: bench/smf_tb.sv */
`timescale 1ns/1ns
module testbench;
    import smf_pkg::*;
    logic mclk_in = 0, rstn_in = 0, target_role_select_in = 0, clock_format_select_in = 0;
    logic queue_direction_in = 0, lsb_first_select_in = 0, two_wire_select_in = 0;
    logic first_byte_command_mode_in = 0, slave_out_fixed_in = 0, gpio_out_value_in = 0;
    logic data_out_line_drive_en_in = 1, clock_pin_drive_en_in = 1, data_in_line_drive_en_in = 0;
    logic clear_all_in = 0, length_wr_in = 0, queue_wr_valid_in = 0, queue_rd_ready_in = 0;
    logic buffer_wr_in = 0, dma_transfer_enable_in = 0, dma_ack_in = 0, sck_in = 0, p_load = 0;
    logic chip_select_input_n_in = 1;
    logic [7:0] serial_clock_divisor_in = 8'h0a, slave_preset_byte_in = 8'h00, p_tx = 8'h00;
    logic [7:0] queue_wr_data_in = 8'h00, buffer_wr_data_in = 8'h00, dma_rdata_in = 8'h00;
    logic [15:0] length_data_in = 16'h0000;
    logic [ADDR_W-1:0] dma_start_address_in = 15'h0000, dma_stop_address_in = 15'h0000;
    logic [ADDR_W-1:0] dma_addr_out;
    logic [LEN_W-1:0] remaining_length_counter_out;
    logic [CNT_W-1:0] queue_byte_count_out;
    logic [7:0] queue_rd_data_out, shift_buffer_reg_out, command_byte_out, dma_wdata_out, p_rx;
    logic queue_wr_ready_out, queue_rd_valid_out, idle_flag_out, fifo_ready_out, half_full_out;
    logic byte_done_out, overflow_out, slave_selected_out, command_valid_out, dma_req_out;
    logic dma_we_out, dma_end_out, sck_out, sck_oe_out, mosi_in, mosi_out, mosi_oe_out;
    logic miso_in, miso_out, miso_oe_out;
    int mismatches, n_tests;
    assign mosi_in = mosi_out;
    smf_top dut_u (.*);
    smf_peer_model peer_u (.sck_in(sck_out), .mosi_in(mosi_out), .miso_out(miso_in),
        .load_in(p_load), .tx_byte_in(p_tx), .rx_byte_out(p_rx));
    initial begin
        forever #20 mclk_in = ~mclk_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 400; i++) begin
            @(negedge mclk_in);
            if (byte_done_out === 1'b1) break;
        end
        if (i == 400) begin
            mismatches++;
            print_verdict();
        end
    endtask
    task automatic t_tx();
        chk(idle_flag_out, 1'b1);
        chk(miso_oe_out, 1'b0);
        chk(mosi_oe_out, 1'b1);
        chk(half_full_out, 1'b1);
        chk(sck_oe_out, 1'b1);
        length_wr_in = 1'b1;
        length_data_in = 16'h0002;
        @(negedge mclk_in);
        length_wr_in = 1'b0;
        queue_wr_valid_in = 1'b1;
        queue_wr_data_in = 8'h3c;
        @(negedge mclk_in);
        queue_wr_data_in = 8'h5a;
        @(negedge mclk_in);
        queue_wr_valid_in = 1'b0;
        wait_done();
        chk(p_rx, 8'h3c);
        wait_done();
        chk(p_rx, 8'h5a);
        chk(remaining_length_counter_out, 12'h000);
        chk(queue_byte_count_out, 4'h0);
    endtask
    task automatic t_dma();
        int k;
        dma_start_address_in = 15'h0000;
        dma_stop_address_in = 15'h0002;
        dma_transfer_enable_in = 1'b1;
        for (k = 0; k < 40 && dma_end_out !== 1'b1; k++) begin
            @(negedge mclk_in);
            // memory answers one cycle after each request
            dma_ack_in = dma_req_out;
            dma_rdata_in = 8'h40 + dma_addr_out[7:0];
        end
        dma_ack_in = 1'b0;
        chk(dma_end_out, 1'b1);
        chk(dma_addr_out, 16'h0002);
        chk(queue_byte_count_out, 4'h2);
        length_wr_in = 1'b1;
        length_data_in = 16'h0002;
        @(negedge mclk_in);
        length_wr_in = 1'b0;
        wait_done();
        chk(p_rx, 8'h40);
        wait_done();
        chk(p_rx, 8'h41);
        dma_transfer_enable_in = 1'b0;
        @(negedge mclk_in);
    endtask
    task automatic t_rx();
        clock_format_select_in = 1'b1;
        lsb_first_select_in = 1'b1;
        queue_direction_in = 1'b1;
        two_wire_select_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        chk(mosi_oe_out, 1'b0);
        p_tx = 8'ha1;
        p_load = 1'b1;
        @(negedge mclk_in);
        p_load = 1'b0;
        length_wr_in = 1'b1;
        length_data_in = 16'hf001;
        @(negedge mclk_in);
        length_wr_in = 1'b0;
        wait_done();
        @(negedge mclk_in);
        chk(queue_byte_count_out, 4'h1);
        chk(queue_rd_data_out, 8'h85);
        chk(shift_buffer_reg_out, 8'h85);
        queue_rd_ready_in = 1'b1;
        @(negedge mclk_in);
        queue_rd_ready_in = 1'b0;
        @(negedge mclk_in);
        chk(queue_byte_count_out, 4'h0);
    endtask
    task automatic t_slave();
        target_role_select_in = 1'b1;
        first_byte_command_mode_in = 1'b1;
        lsb_first_select_in = 1'b0;
        data_in_line_drive_en_in = 1'b1;
        slave_preset_byte_in = 8'h96;
        queue_direction_in = 1'b0;
        queue_wr_valid_in = 1'b1;
        queue_wr_data_in = 8'h11;
        @(negedge mclk_in);
        queue_wr_valid_in = 1'b0;
        chip_select_input_n_in = 1'b0;
        repeat (8) @(negedge mclk_in);
        chk(miso_out, 1'b1);
        chk(miso_oe_out, 1'b1);
        chk(queue_byte_count_out, 4'h1);
        chip_select_input_n_in = 1'b1;
        repeat (8) @(negedge mclk_in);
        chk(miso_oe_out, 1'b0);
    endtask
    initial begin
        repeat (16) @(negedge mclk_in);
        rstn_in = 1'b1;
        @(negedge mclk_in);
        t_tx();
        t_dma();
        t_rx();
        t_slave();
        print_verdict();
    end
endmodule // testbench
bind smf_top smf_asserts chk_u (.*);
